//--- include/sfdp_table_map.svh
`ifndef SFDP_TABLE_MAP_SVH
`define SFDP_TABLE_MAP_SVH

// Placement of this parameter block
`define SFDP_BASE_ADDR      16'h1090
`define SFDP_FIRST_OFS      8'h02
`define NO_OFFSET           8'hFF
`define TABLE_LEN_BYTES     16'h00B0
`define TABLE_SPAN_BYTES    16'h00B2

// Relative byte offsets within the parameter block
`define OFS_PARAM_ID        8'h00
`define OFS_PARAM_LEN       8'h01
`define OFS_WRITE_STYLE     8'h02
`define OFS_ERASE4K_CODE    8'h03
`define OFS_READ_MODES      8'h04
`define OFS_DWORD1_TOP      8'h05
`define OFS_DENSITY_0       8'h06
`define OFS_DENSITY_1       8'h07
`define OFS_DENSITY_2       8'h08
`define OFS_DENSITY_TOP     8'h09
`define OFS_QIO_CYCLES      8'h0A
`define OFS_QIO_OPCODE      8'h0B
`define OFS_QOUT_CYCLES     8'h0C
`define OFS_QOUT_OPCODE     8'h0D
`define OFS_DOUT_CYCLES     8'h0E
`define OFS_DOUT_OPCODE     8'h0F
`define OFS_DIO_CYCLES      8'h10
`define OFS_DIO_OPCODE      8'h11
`define OFS_MODE_FLAGS      8'h12

// Byte values
`define VAL_PARAM_ID        8'hA5
`define VAL_PARAM_LEN       8'hB0
`define VAL_WRITE_STYLE     8'hE7
`define VAL_UNUSED          8'hFF
`define VAL_READ_MODES      8'hB2
`define VAL_DDR_BIT         8'h08
`define VAL_DENSITY_128     8'h07
`define VAL_DENSITY_256     8'h0F
`define VAL_QIO_CYCLES      8'h48
`define VAL_QIO_OPCODE      8'hEB
`define VAL_DIO_CYCLES      8'h88
`define VAL_DIO_OPCODE      8'hBB
`define VAL_MODE_FLAGS      8'hFE

`endif

//--- include/sfdp_table_pkg.sv
package sfdp_table_pkg;

    typedef struct packed {
        logic        start;       // Begin a read at addr
        logic        next;        // Advance to the following byte
        logic        stop;        // End of the read command
        logic        sfdp_space;  // addr is an absolute discoverable-space address
        logic [15:0] addr;
    } read_req_type;

    typedef struct packed {
        logic        strobe;
        logic [15:0] addr;
        logic [7:0]  data;
    } write_try_type;

    typedef struct packed {
        logic        valid;
        logic        known;       // Byte is defined by this block
        logic [7:0]  data;
    } read_ans_type;

    typedef enum logic [1:0] {
        IDLE_ST   = 2'b00,
        STREAM_ST = 2'b01
    } state_type;

endpackage

//--- logic/sfdp_addr_map.sv
`timescale 1ns/100ps
`include "sfdp_table_map.svh"

module sfdp_addr_map (
    input  wire logic [15:0] addr,        // Requested address
    input  wire logic        sfdp_space,  // Absolute discoverable-space address
    output logic      [7:0]  offset,      // Relative offset into this block
    output logic             in_space     // Address falls inside this block
);
    logic [15:0] diff;

    assign diff = addr - `SFDP_BASE_ADDR;

    always_comb begin
        offset   = `NO_OFFSET;
        in_space = 1'b0;
        if (sfdp_space) begin
            // Absolute space starts two bytes in, past the id and length
            if ((addr >= `SFDP_BASE_ADDR) && (diff < `TABLE_LEN_BYTES)) begin
                offset   = diff[7:0] + `SFDP_FIRST_OFS;
                in_space = 1'b1;
            end
        end else if (addr < `TABLE_SPAN_BYTES) begin
            offset   = addr[7:0];
            in_space = 1'b1;
        end
    end
endmodule // sfdp_addr_map

//--- logic/sfdp_param_rom.sv
`timescale 1ns/100ps
`include "sfdp_table_map.svh"

module sfdp_param_rom #(
    parameter bit HIGH_DENSITY = 1'b0,  // 0: 128 Mbit, 1: 256 Mbit
    parameter bit DDR_VARIANT  = 1'b0   // Double-data-rate variant
) (
    input  wire logic [7:0] offset,     // Relative byte offset
    output logic      [7:0] data,       // Byte at that offset
    output logic            known       // Offset is defined here
);
    always_comb begin
        known = 1'b1;
        case (offset)
            `OFS_PARAM_ID:     data = `VAL_PARAM_ID;
            `OFS_PARAM_LEN:    data = `VAL_PARAM_LEN;
            `OFS_WRITE_STYLE:  data = `VAL_WRITE_STYLE;
            `OFS_ERASE4K_CODE: data = `VAL_UNUSED;
            `OFS_READ_MODES:   data = DDR_VARIANT ? (`VAL_READ_MODES | `VAL_DDR_BIT)
                                                  : `VAL_READ_MODES;
            `OFS_DWORD1_TOP:   data = `VAL_UNUSED;
            `OFS_DENSITY_0,
            `OFS_DENSITY_1,
            `OFS_DENSITY_2:    data = `VAL_UNUSED;
            `OFS_DENSITY_TOP:  data = HIGH_DENSITY ? `VAL_DENSITY_256
                                                   : `VAL_DENSITY_128;
            `OFS_QIO_CYCLES:   data = `VAL_QIO_CYCLES;
            `OFS_QIO_OPCODE:   data = `VAL_QIO_OPCODE;
            `OFS_QOUT_CYCLES,
            `OFS_QOUT_OPCODE:  data = `VAL_UNUSED;
            `OFS_DOUT_CYCLES,
            `OFS_DOUT_OPCODE:  data = `VAL_UNUSED;
            `OFS_DIO_CYCLES:   data = `VAL_DIO_CYCLES;
            `OFS_DIO_OPCODE:   data = `VAL_DIO_OPCODE;
            `OFS_MODE_FLAGS:   data = `VAL_MODE_FLAGS;
            default: begin
                // Later dwords live elsewhere; erased-flash value is the safe fill
                data  = `VAL_UNUSED;
                known = 1'b0;
            end
        endcase
    end
endmodule // sfdp_param_rom

//--- logic/sfdp_basic_param_table.sv
`timescale 1ns/100ps
`include "sfdp_table_map.svh"
// How it works
// - Offset 00h returns identifier byte A5h.
// - Offset 01h returns length B0h for both densities.
// - Absolute address 1090h maps to relative offset 02h.
// - First basic byte reads E7h: status-write style, big buffer, no 4KB erase.
// - Second basic byte reads FFh: no uniform 4KB erase opcode.
// - Third basic byte reads B2h; DDR bit set only on DDR variant.
// - Fourth byte of dword one reads FFh.
// - Density dword: three FFh bytes, then 07h or 0Fh by density.
// - Quad I/O cycle byte reads 48h.
// - Quad I/O opcode byte reads EBh.
// - Quad-output cycle and opcode bytes read FFh.
// - Dual-output cycle and opcode bytes read FFh.
// - Dual I/O cycle byte reads 88h.
// - Dual I/O opcode byte reads BBh.
// - Fifth dword first byte reads FEh.

module sfdp_basic_param_table #(
    parameter bit HIGH_DENSITY = 1'b0,  // 0: 128 Mbit, 1: 256 Mbit
    parameter bit DDR_VARIANT  = 1'b0   // Double-data-rate variant
) (
    input  wire logic                         clk,            // 50 MHz clock
    input  wire logic                         reset,          // Synchronous, active high
    input  wire logic                         enable,         // Clock enable
    input  wire sfdp_table_pkg::read_req_type  req,            // Read request
    input  wire sfdp_table_pkg::write_try_type write_try,      // Write attempt
    output sfdp_table_pkg::read_ans_type       ans,            // Read answer
    output logic                              streaming,      // Read command open
    output logic                              write_refused   // Write attempt discarded
);
    import sfdp_table_pkg::*;

    state_type    state_reg;
    state_type    state_next;
    logic [7:0]   ptr_reg;
    logic [7:0]   ptr_next;
    read_ans_type ans_reg;
    logic         refused_reg;
    logic [7:0]   start_ofs;
    logic         start_ok;
    logic [7:0]   look_ofs;
    logic [7:0]   look_data;
    logic         look_known;
    logic         taken;

    function automatic logic [7:0] advance(input logic [7:0] ofs);
        // Saturate so a long stream past the end keeps reading fill bytes
        advance = (ofs == `NO_OFFSET) ? `NO_OFFSET : ofs + 8'h01;
    endfunction

    sfdp_addr_map u_map (
        .addr       (req.addr),
        .sfdp_space (req.sfdp_space),
        .offset     (start_ofs),
        .in_space   (start_ok)
    );

    sfdp_param_rom #(
        .HIGH_DENSITY (HIGH_DENSITY),
        .DDR_VARIANT  (DDR_VARIANT)
    ) u_rom (
        .offset (look_ofs),
        .data   (look_data),
        .known  (look_known)
    );

    // A new start wins over next in the same cycle
    assign taken    = req.start || ((state_reg == STREAM_ST) && req.next);
    assign look_ofs = req.start ? (start_ok ? start_ofs : `NO_OFFSET)
                                : advance(ptr_reg);

    always_comb begin
        state_next = state_reg;
        ptr_next   = ptr_reg;
        case (state_reg)
            IDLE_ST: begin
                if (req.start) begin
                    state_next = STREAM_ST;
                    ptr_next   = look_ofs;
                end
            end
            STREAM_ST: begin
                if (req.start) begin
                    ptr_next = look_ofs;
                end else if (req.stop) begin
                    state_next = IDLE_ST;
                end else if (req.next) begin
                    ptr_next = look_ofs;
                end
            end
            default: begin
                state_next = IDLE_ST;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= IDLE_ST;
            ptr_reg   <= `NO_OFFSET;
        end else if (enable) begin
            state_reg <= state_next;
            ptr_reg   <= ptr_next;
        end
    end

    // Answer bytes come only from the constant lookup, so every read repeats
    always_ff @(posedge clk) begin
        if (reset) begin
            ans_reg <= '0;
        end else if (enable) begin
            ans_reg.valid <= taken;
            if (taken) begin
                ans_reg.data  <= look_data;
                ans_reg.known <= look_known;
            end
        end
    end

    // Writes are acknowledged as refused and reach no storage
    always_ff @(posedge clk) begin
        if (reset) begin
            refused_reg <= 1'b0;
        end else if (enable) begin
            refused_reg <= write_try.strobe;
        end
    end

    assign ans           = ans_reg;
    assign streaming     = (state_reg == STREAM_ST);
    assign write_refused = refused_reg;

    // Checks
    property p_byte(logic [15:0] ofs, logic [7:0] exp);
        @(posedge clk) disable iff (reset)
        (enable && req.start && !req.sfdp_space && (req.addr == ofs))
            |=> (ans.valid && ans.known && (ans.data == exp));
    endproperty

    sequence s_start_at(logic [15:0] ofs);
        enable && req.start && !req.sfdp_space && (req.addr == ofs);
    endsequence

    sequence s_step;
        enable && !req.start && !req.stop && req.next;
    endsequence

    a_id_byte: assert property (p_byte(16'h0000, `VAL_PARAM_ID))
        else $error("identifier byte wrong");

    a_len_byte: assert property (p_byte(16'h0001, `VAL_PARAM_LEN))
        else $error("length byte wrong");

    a_sfdp_base: assert property (@(posedge clk) disable iff (reset)
        (enable && req.start && req.sfdp_space && (req.addr == `SFDP_BASE_ADDR))
            |=> (ans.valid && (ans.data == `VAL_WRITE_STYLE)) ##0 (ptr_reg == `SFDP_FIRST_OFS))
        else $error("base address not mapped to offset 02h");

    a_write_style: assert property (@(posedge clk) disable iff (reset)
        s_start_at(16'h0002) |=> (ans.data == `VAL_WRITE_STYLE) && (ans.data[4:3] == 2'b00)
            && ans.data[2] && (ans.data[1:0] == 2'b11))
        else $error("write style byte wrong");

    a_erase_code: assert property (p_byte(16'h0003, `VAL_UNUSED))
        else $error("4KB erase opcode byte wrong");

    a_read_modes: assert property (@(posedge clk) disable iff (reset)
        s_start_at(16'h0004) |=> (ans.data[7:4] == 4'hB) && (ans.data[3] == DDR_VARIANT)
            && (ans.data[2:1] == 2'b01) && !ans.data[0])
        else $error("read mode byte wrong");

    a_dword_top: assert property (p_byte(16'h0005, `VAL_UNUSED))
        else $error("dword one top byte wrong");

    a_density: assert property (@(posedge clk) disable iff (reset)
        s_start_at(16'h0006) ##1 s_step ##1 s_step ##1 s_step
            |-> (ans.data == (HIGH_DENSITY ? `VAL_DENSITY_256 : `VAL_DENSITY_128))
            && ($past(ans.data) == `VAL_UNUSED))
        else $error("density dword wrong");

    a_quad_io: assert property (@(posedge clk) disable iff (reset)
        s_start_at(16'h000A) ##1 s_step
            |-> ##1 (ans.data == `VAL_QIO_OPCODE) && ($past(ans.data) == `VAL_QIO_CYCLES))
        else $error("quad I/O bytes wrong");

    a_quad_out: assert property (@(posedge clk) disable iff (reset)
        s_start_at(16'h000C) ##1 s_step
            |-> ##1 (ans.data == `VAL_UNUSED) && ($past(ans.data) == `VAL_UNUSED))
        else $error("quad output bytes wrong");

    a_dual_out: assert property (@(posedge clk) disable iff (reset)
        s_start_at(16'h000E) ##1 s_step
            |-> ##1 (ans.data == `VAL_UNUSED) && ($past(ans.data) == `VAL_UNUSED))
        else $error("dual output bytes wrong");

    a_dual_cycles: assert property (p_byte(16'h0010, `VAL_DIO_CYCLES))
        else $error("dual I/O cycle byte wrong");

    a_dual_code: assert property (p_byte(16'h0011, `VAL_DIO_OPCODE))
        else $error("dual I/O opcode wrong");

    a_mode_flags: assert property (p_byte(16'h0012, `VAL_MODE_FLAGS))
        else $error("mode flag byte wrong");

    a_read_repeat: assert property (@(posedge clk) disable iff (reset)
        (enable && req.start) ##1 (enable && req.start && $stable(req.addr)
            && $stable(req.sfdp_space)) |=> $stable(ans.data))
        else $error("repeated read differs");

    a_write_none: assert property (@(posedge clk) disable iff (reset)
        (enable && write_try.strobe && !taken) |=> (write_refused && $stable(ans.data)
            && $stable(ptr_reg)))
        else $error("write attempt changed table");

    a_freeze: assert property (@(posedge clk) disable iff (reset)
        !enable |=> ($stable(ans) && $stable(ptr_reg) && $stable(streaming)))
        else $error("state moved while disabled");

endmodule // sfdp_basic_param_table

//--- tb/host_reader.sv
`timescale 1ns/100ps

module host_reader (
    input  wire logic                     clk,        // Device clock
    output sfdp_table_pkg::read_req_type  req,        // Read request to the table
    output sfdp_table_pkg::write_try_type write_try   // Write attempt to the table
);
    import sfdp_table_pkg::*;

    initial begin
        req = '0;
        write_try = '0;
    end

    // Requests move only after a falling edge, so the table samples settled values
    task automatic issue(input logic start, input logic next, input logic stop,
                         input logic space, input logic [15:0] addr);
        @(negedge clk);
        req.start      <= start;
        req.next       <= next;
        req.stop       <= stop;
        req.sfdp_space <= space;
        // Idle address lines are not held: a stale copy could hide a missed sample
        req.addr       <= (start | next | stop) ? addr : ~req.addr;
    endtask

    task automatic try_write(input logic strobe, input logic [15:0] addr,
                             input logic [7:0] data);
        @(negedge clk);
        write_try.strobe <= strobe;
        write_try.addr   <= strobe ? addr : ~write_try.addr;
        write_try.data   <= strobe ? data : ~write_try.data;
    endtask

    // Next parameter starts one past the length byte plus the count it reports
    function automatic logic [15:0] next_param(input logic [15:0] len_ofs,
                                               input logic [7:0] len);
        return len_ofs + 16'h0001 + {8'h00, len};
    endfunction
endmodule // host_reader

//--- tb/tb.sv
`timescale 1ns/100ps

module tb;
    import sfdp_table_pkg::*;

    logic          clk;
    logic          reset;
    logic          enable;
    read_req_type  req;
    write_try_type write_try;
    read_ans_type  ans;
    read_ans_type  ans_hi;
    logic          streaming;
    logic          write_refused;
    int            errors;
    int            n_checks;
    logic [7:0]    exp_lo [0:18];
    logic [7:0]    exp_hi [0:18];

    initial clk = 1'b0;
    always #10 clk = ~clk;

    host_reader host_reader_inst (.clk(clk), .req(req), .write_try(write_try));

    sfdp_basic_param_table sfdp_basic_param_table_inst (
        .clk(clk), .reset(reset), .enable(enable), .req(req), .write_try(write_try),
        .ans(ans), .streaming(streaming), .write_refused(write_refused));

    // Second variant: high density with double data rate, same request stream
    sfdp_basic_param_table #(.HIGH_DENSITY(1'b1), .DDR_VARIANT(1'b1))
        sfdp_basic_param_table_inst2 (
        .clk(clk), .reset(reset), .enable(enable), .req(req), .write_try(write_try),
        .ans(ans_hi), .streaming(), .write_refused());

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic read_run(input logic [15:0] a, input logic sp, input int first, input int n);
        host_reader_inst.issue(1'b1, 1'b0, 1'b0, sp, a);
        for (int i = 0; i < n; i++) begin
            host_reader_inst.issue(1'b0, i < n - 1, i == n - 1, sp, a);
            check("valid", {7'h00, ans.valid}, 8'h01);
            check("data", ans.data, exp_lo[first+i]);
            check("data_hi", ans_hi.data, exp_hi[first+i]);
            check("known", {7'h00, ans.known}, 8'h01);
        end
        host_reader_inst.issue(1'b0, 1'b0, 1'b0, sp, a);
        check("streaming", {7'h00, streaming}, 8'h00);
        check("valid_end", {7'h00, ans.valid}, 8'h00);
    endtask

    task automatic one_read(input logic [15:0] a, input logic sp, input logic [7:0] d,
                            input logic k);
        host_reader_inst.issue(1'b1, 1'b0, 1'b0, sp, a);
        host_reader_inst.issue(1'b0, 1'b0, 1'b1, sp, a);
        check("valid", {7'h00, ans.valid}, 8'h01);
        check("data", ans.data, d);
        check("known", {7'h00, ans.known}, {7'h00, k});
        host_reader_inst.issue(1'b0, 1'b0, 1'b0, sp, a);
    endtask

    task automatic t_length;
        logic [15:0] nxt;
        one_read(16'h0001, 1'b0, 8'hB0, 1'b1);
        nxt = host_reader_inst.next_param(16'h0001, ans.data);
        check("next_param", nxt[7:0], 8'hB2);
        one_read(16'h00B1, 1'b0, 8'hFF, 1'b0);
        one_read(nxt, 1'b0, 8'hFF, 1'b0);
    endtask

    task automatic t_absolute;
        read_run(16'h1090, 1'b1, 2, 3);
        read_run(16'h10A0, 1'b1, 18, 1);
        one_read(16'h108F, 1'b1, 8'hFF, 1'b0);
        one_read(16'h1140, 1'b1, 8'hFF, 1'b0);
    endtask

    task automatic t_refuse_and_write;
        host_reader_inst.issue(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
        host_reader_inst.issue(1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        check("lone_next", {7'h00, ans.valid}, 8'h00);
        host_reader_inst.try_write(1'b1, 16'h000A, 8'h00);
        host_reader_inst.try_write(1'b0, 16'h0000, 8'h00);
        check("write_refused", {7'h00, write_refused}, 8'h01);
        host_reader_inst.try_write(1'b0, 16'h0000, 8'h00);
        check("write_refused_end", {7'h00, write_refused}, 8'h00);
        one_read(16'h000A, 1'b0, 8'h48, 1'b1);
    endtask

    task automatic t_freeze;
        host_reader_inst.issue(1'b1, 1'b0, 1'b0, 1'b0, 16'h000A);
        host_reader_inst.issue(1'b0, 1'b1, 1'b0, 1'b0, 16'h000A);
        enable <= 1'b0;
        repeat (3) @(negedge clk);
        check("frozen_valid", {7'h00, ans.valid}, 8'h01);
        check("frozen_data", ans.data, 8'h48);
        enable <= 1'b1;
        host_reader_inst.issue(1'b0, 1'b0, 1'b1, 1'b0, 16'h000A);
        check("resumed_data", ans.data, 8'hEB);
        host_reader_inst.issue(1'b0, 1'b0, 1'b0, 1'b0, 16'h000A);
    endtask

    initial begin
        errors = 0;
        n_checks = 0;
        reset = 1'b1;
        enable = 1'b1;
        exp_lo = '{8'hA5, 8'hB0, 8'hE7, 8'hFF, 8'hB2, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07,
                   8'h48, 8'hEB, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h88, 8'hBB, 8'hFE};
        exp_hi = exp_lo;
        exp_hi[4] = 8'hBA;
        exp_hi[9] = 8'h0F;
        repeat (8) @(negedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check("reset_data", ans.data, 8'h00);
        read_run(16'h0000, 1'b0, 0, 19);
        t_length;
        t_absolute;
        t_refuse_and_write;
        t_freeze;
        read_run(16'h0000, 1'b0, 0, 19);
        print_verdict;
    end

    // Whole run needs about 90 cycles; over sixteen times that means a hang
    initial begin
        repeat (1500) @(posedge clk);
        errors++;
        $display("Error watchdog expected done seen hang");
        print_verdict;
    end
endmodule // tb
